// *** fsps_flash_model.sv ***
// Purpose: Flash array stand-in that times each operation.
// Assumes: One request at a time; lat sets a prompt or slow answer.
// Notes: Buffer reads follow peek so the bench can inspect slots.
`timescale 1ns/10ps
module fsps_flash_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [3:0] lat,
  input wire logic [5:0] peek,
  output logic [5:0] buf_rd_addr,
  output logic flash_done
);
  logic [4:0] cnt_q;
  assign buf_rd_addr = peek;
  // Done is a single pulse, never a level
  always_ff @(posedge clk) begin
    cnt_q <= rst ? 5'h00 : req_valid ? 5'(lat) + 5'h02 : cnt_q - 5'(cnt_q != 5'h00);
    flash_done <= !rst && !req_valid && cnt_q == 5'h01;
  end
endmodule // fsps_flash_model

// *** fsps_pkg.sv ***
// Purpose: Shared constants and types for the flash self-program sequencer.
// Assumes: 32-bit APB, 16-bit address pointer, one word per buffer slot.
// Notes: Pointer bit 0 selects a byte for loads; stores ignore it.
package fsps_pkg;
  // Register byte offsets
  localparam logic [7:0] FSPS_OFF_CTRL = 8'h00;
  localparam logic [7:0] FSPS_OFF_PTR = 8'h04;
  localparam logic [7:0] FSPS_OFF_DATA = 8'h08;
  localparam logic [7:0] FSPS_OFF_CMD = 8'h0C;
  localparam logic [7:0] FSPS_OFF_LOAD = 8'h10;
  // Control field positions
  localparam int FSPS_B_EN = 0;
  localparam int FSPS_B_ERASE = 1;
  localparam int FSPS_B_WRITE = 2;
  localparam int FSPS_B_LOCK = 3;
  localparam int FSPS_B_REEN = 4;
  localparam int FSPS_B_BUSY = 6;
  localparam int FSPS_B_IE = 7;
  // Command field positions and load result flag
  localparam int FSPS_B_STORE = 0;
  localparam int FSPS_B_LOADI = 1;
  localparam int FSPS_B_SPECIAL = 8;
  // Low five control bits that start a command
  localparam logic [4:0] FSPS_PAT_FILL = 5'h01;
  localparam logic [4:0] FSPS_PAT_ERASE = 5'h03;
  localparam logic [4:0] FSPS_PAT_WRITE = 5'h05;
  localparam logic [4:0] FSPS_PAT_LOCK = 5'h09;
  localparam logic [4:0] FSPS_PAT_REEN = 5'h11;
  // Timing windows in clock cycles after the control write
  localparam logic [2:0] FSPS_STORE_WIN = 3'h4;
  localparam logic [2:0] FSPS_LOAD_WIN = 3'h3;
  // Pointer values for fuse and lock reads
  localparam logic [15:0] FSPS_PTR_FUSE_LO = 16'h0000;
  localparam logic [15:0] FSPS_PTR_LOCK = 16'h0001;
  localparam logic [15:0] FSPS_PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] FSPS_PTR_FUSE_HI = 16'h0003;
  // Pointer layout: word index sits above the byte bit
  localparam int FSPS_WORD_LSB = 1;
  localparam int FSPS_WORD_W = 6;
  localparam int FSPS_PAGE_W = 8;
  localparam int FSPS_PAGE_LSB = FSPS_WORD_LSB + FSPS_WORD_W;
  localparam logic [FSPS_PAGE_W-1:0] FSPS_RWW_PAGES = 8'hE0;
  localparam logic [31:0] FSPS_CTRL_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    FSPS_OP_NONE,
    FSPS_OP_ERASE,
    FSPS_OP_WRITE,
    FSPS_OP_LOCK
  } fsps_op_t;

  // Request towards the flash array
  typedef struct packed {
    fsps_op_t op;
    logic [FSPS_PAGE_W-1:0] page;
    logic [3:0] boot_lock;
  } fsps_flash_req_t;
endpackage

// *** fsps_sequencer.sv ***
// Purpose: Flash self-program sequencer: page buffer, erase, write, lock set and fuse reads.
// Assumes: APB master from the CPU side; flash array times each operation and pulses done.
// Notes: Store and load instructions are issued as writes to the command register.
// Functional notes
// - Buffer loads accepted before erase or between erase and write.
// - Buffer words may be loaded at any position in any order.
// - Erase pattern plus store within four cycles erases the pointer's page.
// - Erasing the busy-capable section keeps other section readable; else CPU halts.
// - Fill pattern plus store within four cycles loads data pair at word index.
// - Buffer clears after page write, on section re-enable, and on reset.
// - EEPROM write during page loading discards loaded buffer data.
// - Write pattern plus store within four cycles writes buffer to page.
// - Writing the busy-capable section keeps other readable; else CPU halts.
// - Interrupt enable gives a level request while program enable is clear.
// - Erase or write of a busy-capable page blocks that section's reads and sets busy flag.
// - Lock pattern plus store programs boot lock bits cleared in data low 5..2.
// - Lock programming blocks no section and halts nothing.
// - EEPROM write busy blocks all program commands and fuse or lock reads.
// - Lock read: pointer one, lock op, load within three cycles returns lock bits.
// - Lock op and enable self-clear on read, load or store timeout.
// - Pointer zero with lock op returns fuse low byte on load.
// - Control bit layout fixed; all bits reset to zero.
// - Section re-enable during buffer loading aborts and discards the load.
// - Pointer three returns fuse high, pointer two extended fuse.
// - Programmed fuse and lock bits read zero, unprogrammed read one.
`timescale 1ns/10ps
module fsps_sequencer #(
  parameter int PAGE_WORDS = 64,
  parameter logic [fsps_pkg::FSPS_PAGE_W-1:0] RWW_PAGES = fsps_pkg::FSPS_RWW_PAGES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eeprom_write_busy,
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  input wire logic [7:0] fuse_ext_byte,
  input wire logic [3:0] boot_lock_state,
  input wire logic [1:0] memory_lock_state,
  input wire logic flash_done,
  input wire logic [fsps_pkg::FSPS_WORD_W-1:0] buf_rd_addr,
  output logic [15:0] buf_rd_data,
  output fsps_pkg::fsps_flash_req_t flash_req,
  output logic flash_req_valid,
  output logic cpu_halt,
  output logic rww_read_block,
  output logic irq
);
  import fsps_pkg::*;

  typedef enum logic [1:0] {FSPS_IDLE, FSPS_ARMED, FSPS_BUSY} fsps_state_t;

  fsps_state_t state_q;
  logic en_q, erase_q, write_q, lock_q, reen_q, busy_q, ie_q;
  logic [2:0] cnt_q;
  logic [15:0] ptr_q;
  logic [15:0] data_q;
  logic [8:0] load_q;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] buf_vld_q;
  logic eeb_q;

  // Bus decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wr = access && pwrite;
  wire hit_ctrl = paddr == FSPS_OFF_CTRL;
  wire hit_ptr = paddr == FSPS_OFF_PTR;
  wire hit_data = paddr == FSPS_OFF_DATA;
  wire hit_cmd = paddr == FSPS_OFF_CMD;
  wire hit_load = paddr == FSPS_OFF_LOAD;
  wire mapped = hit_ctrl || hit_ptr || hit_data || hit_cmd || hit_load;

  wire [7:0] ctrl_rd = {ie_q, busy_q, 1'b0, reen_q, lock_q, write_q, erase_q, en_q};
  wire [4:0] pat = pwdata[4:0];
  wire ctrl_wr = wr && hit_ctrl;
  // Commands refused while an operation or an EEPROM write is in progress
  wire cmd_ok = ctrl_wr && state_q != FSPS_BUSY && !eeprom_write_busy;
  wire arm_fill = cmd_ok && pat == FSPS_PAT_FILL;
  wire arm_any = cmd_ok && (pat == FSPS_PAT_FILL || pat == FSPS_PAT_ERASE ||
    pat == FSPS_PAT_WRITE || pat == FSPS_PAT_LOCK || pat == FSPS_PAT_REEN);

  wire store = wr && hit_cmd && pwdata[FSPS_B_STORE];
  wire loadi = wr && hit_cmd && pwdata[FSPS_B_LOADI];
  wire armed = state_q == FSPS_ARMED;
  wire store_ok = armed && store && cnt_q < FSPS_STORE_WIN && !eeprom_write_busy;
  wire load_ok = armed && loadi && cnt_q < FSPS_LOAD_WIN && lock_q;
  wire timeout = armed && cnt_q >= FSPS_STORE_WIN;

  wire do_fill = store_ok && !erase_q && !write_q && !lock_q && !reen_q;
  wire do_erase = store_ok && erase_q;
  wire do_write = store_ok && write_q;
  wire do_lock = store_ok && lock_q;
  wire do_reen = store_ok && reen_q;

  wire [FSPS_WORD_W-1:0] word_idx = ptr_q[FSPS_PAGE_LSB-1:FSPS_WORD_LSB];
  wire [FSPS_PAGE_W-1:0] page_idx = ptr_q[FSPS_PAGE_LSB+FSPS_PAGE_W-1:FSPS_PAGE_LSB];
  // Pages below the boundary belong to the section that can be blocked
  wire page_rww = page_idx < RWW_PAGES;

  // A new EEPROM write while words are loaded wipes them
  wire ee_rise = eeprom_write_busy && !eeb_q;
  wire buf_clear = (do_reen) || (arm_any && pat == FSPS_PAT_REEN) ||
    (state_q == FSPS_BUSY && flash_done && flash_req.op == FSPS_OP_WRITE) ||
    (ee_rise && |buf_vld_q);

  // Fuse and lock read mux; bits read as stored, zero means programmed
  logic [7:0] lock_byte;
  always_comb begin
    unique case (ptr_q)
      FSPS_PTR_FUSE_LO: lock_byte = fuse_low_byte;
      FSPS_PTR_LOCK: lock_byte = {2'b11, boot_lock_state, memory_lock_state};
      FSPS_PTR_FUSE_EXT: lock_byte = fuse_ext_byte;
      FSPS_PTR_FUSE_HI: lock_byte = fuse_high_byte;
      default: lock_byte = 8'hFF;
    endcase
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[7:0] = ctrl_rd;
    end else if (hit_ptr) begin
      rd_mux[15:0] = ptr_q;
    end else if (hit_data) begin
      rd_mux[15:0] = data_q;
    end else if (hit_load) begin
      rd_mux[8:0] = load_q;
    end
  end

  // APB answer: registered, so every access completes with no wait state
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= setup && !pwrite ? rd_mux : 32'h0000_0000;
      pslverr <= setup && !mapped;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= 16'h0000;
      data_q <= 16'h0000;
      eeb_q <= 1'b0;
    end else begin
      eeb_q <= eeprom_write_busy;
      if (wr && hit_ptr) ptr_q <= pwdata[15:0];
      if (wr && hit_data) data_q <= pwdata[15:0];
    end
  end

  // Sequencer state and control bits
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= FSPS_IDLE;
      {ie_q, busy_q, reen_q, lock_q, write_q, erase_q, en_q} <= 7'h00;
      cnt_q <= 3'h0;
      flash_req <= '0;
      flash_req_valid <= 1'b0;
      cpu_halt <= 1'b0;
    end else begin
      flash_req_valid <= 1'b0;
      if (ctrl_wr) ie_q <= pwdata[FSPS_B_IE];
      if (cnt_q < FSPS_STORE_WIN) cnt_q <= cnt_q + 3'h1;
      unique case (state_q)
        FSPS_IDLE: begin
          if (arm_any) begin
            state_q <= FSPS_ARMED;
            cnt_q <= 3'h0;
            {reen_q, lock_q, write_q, erase_q, en_q} <= pat;
          end
        end
        FSPS_ARMED: begin
          if (do_erase || do_write || do_lock) begin
            state_q <= FSPS_BUSY;
            flash_req.op <= do_erase ? FSPS_OP_ERASE : do_write ? FSPS_OP_WRITE : FSPS_OP_LOCK;
            flash_req.page <= page_idx;
            // Data pair plays no part in erase or write
            flash_req.boot_lock <= do_lock ? data_q[5:2] : 4'h0;
            flash_req_valid <= 1'b1;
            if (!do_lock) begin
              busy_q <= busy_q || page_rww;
              cpu_halt <= !page_rww;
            end
          end else if (store_ok || load_ok || timeout) begin
            state_q <= FSPS_IDLE;
            {reen_q, lock_q, write_q, erase_q, en_q} <= 5'h00;
            if (do_fill || do_reen) busy_q <= 1'b0;
          end else if (arm_any) begin
            cnt_q <= 3'h0;
            {reen_q, lock_q, write_q, erase_q, en_q} <= pat;
          end
        end
        FSPS_BUSY: begin
          if (flash_done) begin
            state_q <= FSPS_IDLE;
            {reen_q, lock_q, write_q, erase_q, en_q} <= 5'h00;
            cpu_halt <= 1'b0;
          end
        end
        default: state_q <= FSPS_IDLE;
      endcase
    end
  end

  // Section stays blocked until a re-enable or buffer fill store clears busy
  always_ff @(posedge clk) begin
    if (rst) begin
      rww_read_block <= 1'b0;
      irq <= 1'b0;
    end else begin
      rww_read_block <= busy_q;
      irq <= ie_q && !en_q;
    end
  end

  // Load result: special byte only when the read is allowed
  always_ff @(posedge clk) begin
    if (rst) begin
      load_q <= 9'h000;
    end else if (loadi) begin
      if (load_ok && !eeprom_write_busy) begin
        load_q <= {1'b1, lock_byte};
      end else begin
        load_q <= 9'h000;
      end
    end
  end

  // Page buffer: random word order, one valid bit per slot
  genvar gi;
  generate
    for (gi = 0; gi < PAGE_WORDS; gi++) begin : g_buf
      wire hit = do_fill && word_idx == FSPS_WORD_W'(gi);
      always_ff @(posedge clk) begin
        if (rst || buf_clear) begin
          buf_vld_q[gi] <= 1'b0;
        end else if (hit && !buf_vld_q[gi]) begin
          buf_vld_q[gi] <= 1'b1;
        end
      end
      // Unloaded slots read as erased flash
      always_ff @(posedge clk) begin
        if (rst || buf_clear) begin
          buf_mem[gi] <= 16'hFFFF;
        end else if (hit && !buf_vld_q[gi]) begin
          buf_mem[gi] <= data_q;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_rd_data <= 16'hFFFF;
    end else begin
      buf_rd_data <= buf_mem[buf_rd_addr];
    end
  end
endmodule // fsps_sequencer

// *** fsps_sequencer_sva.sv ***
// Purpose: Port-level checks for the flash self-program sequencer.
// Assumes: Zero-wait APB slave; flash_done is a one-cycle pulse.
// Notes: Attached by bind; sees top-level ports only.
`timescale 1ns/10ps
module fsps_sequencer_sva #(
  parameter logic [fsps_pkg::FSPS_PAGE_W-1:0] RWW_PAGES = fsps_pkg::FSPS_RWW_PAGES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire fsps_pkg::fsps_flash_req_t flash_req,
  input wire logic flash_req_valid,
  input wire logic flash_done,
  input wire logic cpu_halt,
  input wire logic rww_read_block,
  input wire logic irq
);
  import fsps_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_prog; flash_req_valid && flash_req.op inside {FSPS_OP_ERASE, FSPS_OP_WRITE}; endsequence
  a_zero_wait: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_unmapped_err: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
    else $error("unmapped access without error");
  a_req_pulse: assert property (flash_req_valid |=> !flash_req_valid)
    else $error("request longer than one cycle");
  a_halt_no_read_while_write_section: assert property (s_prog ##0 flash_req.page >= RWW_PAGES |-> ##[0:1] cpu_halt)
    else $error("no halt for protected page");
  a_busy_rww: assert property (s_prog ##0 flash_req.page < RWW_PAGES |-> ##[0:2] rww_read_block)
    else $error("section not blocked");
  a_halt_until_done: assert property (cpu_halt && !flash_done |=> cpu_halt)
    else $error("halt dropped early");
  a_halt_release: assert property (flash_done |=> !cpu_halt)
    else $error("halt held after done");
  a_irq_quiet: assert property (flash_req_valid |-> !irq ##1 !irq)
    else $error("ready request while enabled");
  a_lock_free: assert property (flash_req_valid && flash_req.op == FSPS_OP_LOCK |=> !cpu_halt)
    else $error("halt during lock set");
endmodule // fsps_sequencer_sva
bind fsps_sequencer fsps_sequencer_sva #(.RWW_PAGES(RWW_PAGES)) u_sva (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .flash_req(flash_req), .flash_req_valid(flash_req_valid), .flash_done(flash_done),
  .cpu_halt(cpu_halt), .rww_read_block(rww_read_block), .irq(irq));

// *** test_flash_self_program_sequencer.sv ***
// Purpose: Self-checking bench for the flash self-program sequencer.
// Assumes: Zero-wait APB slave; flash model answers after a random delay.
// Notes: Reads and flash requests are matched against queued notes.
`timescale 1ns/10ps
module test_flash_self_program_sequencer;
  import fsps_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, eew = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rnd = 32'h0001_371E, prdata;
  logic [7:0] fz [4] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [3:0] boot_loader_section = 4'hF, lat = 4'h1;
  logic [1:0] mls = 2'h3;
  logic [5:0] peek = 6'h00, bra;
  logic [15:0] brd, wd [2];
  logic pready, pslverr, done, req_v, halt, rblk, irq;
  fsps_flash_req_t req;
  logic [31:0] rd_q [$], req_q [$];
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  fsps_sequencer #(.PAGE_WORDS(64), .RWW_PAGES(FSPS_RWW_PAGES)) DUT (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .eeprom_write_busy(eew),
    .fuse_low_byte(fz[0]), .fuse_high_byte(fz[3]), .fuse_ext_byte(fz[2]),
    .boot_lock_state(boot_loader_section), .memory_lock_state(mls), .flash_done(done), .buf_rd_addr(bra),
    .buf_rd_data(brd), .flash_req(req), .flash_req_valid(req_v), .cpu_halt(halt),
    .rww_read_block(rblk), .irq(irq));
  fsps_flash_model u_flash (.clk(clk), .rst(rst), .req_valid(req_v), .lat(lat), .peek(peek),
    .buf_rd_addr(bra), .flash_done(done));
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Request held until pready seen high at a falling edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    penable <= 1'b0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(negedge clk); while (pready !== 1'b1);
    @(posedge clk);
  endtask
  task automatic gap(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Back to back so the store lands inside the window
  task automatic spm(input logic [7:0] c, input logic [31:0] s);
    bus(1'b1, FSPS_OFF_CTRL, 32'(c));
    bus(1'b1, FSPS_OFF_CMD, s);
    gap(1);
  endtask
  task automatic fill(input logic [5:0] w, input logic [15:0] d);
    bus(1'b1, FSPS_OFF_PTR, {25'h0, w, 1'b0});
    bus(1'b1, FSPS_OFF_DATA, 32'(d));
    spm(8'h01, 32'h1);
  endtask
  task automatic bchk(input logic [5:0] a, input logic [15:0] e);
    peek <= a;
    repeat (3) @(negedge clk);
    check(32'(brd), 32'(e));
    @(posedge clk);
  endtask
  task automatic op(input logic [7:0] c, input logic [15:0] p, input fsps_op_t o,
                    input logic [3:0] bl);
    rnd = lfsr(rnd);
    lat <= rnd[3:0];
    bus(1'b1, FSPS_OFF_PTR, 32'(p));
    req_q.push_back(32'({o, p[14:7], bl}));
    spm(c, 32'h1);
    repeat (64) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    repeat (3) @(posedge clk);
  endtask
  always @(negedge clk) begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0) check(prdata, rd_q.pop_front());
    if (req_v !== 1'b0) check(32'(req), req_q.size() > 0 ? req_q.pop_front() : 32'hFFFF_FFFF);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rnd = lfsr(rnd);
    fz <= '{rnd[7:0], 8'hFF, rnd[15:8], rnd[23:16]};
    boot_loader_section <= rnd[27:24];
    mls <= rnd[29:28];
    @(posedge clk);
    rd(FSPS_OFF_CTRL, FSPS_CTRL_RST);
    rd(8'h20, 32'h0);
    gap(1);
    bchk(6'h05, 16'hFFFF);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      wd[i] = rnd[15:0];
      fill(6'h05 - 6'(3 * i), wd[i]);
    end
    bchk(6'h05, wd[0]);
    op(8'h03, 16'h7800, FSPS_OP_ERASE, 4'h0);
    bchk(6'h02, wd[1]);
    op(8'h05, 16'h7800, FSPS_OP_WRITE, 4'h0);
    bchk(6'h05, 16'hFFFF);
    op(8'h83, 16'h0800, FSPS_OP_ERASE, 4'h0);
    rd(FSPS_OFF_CTRL, 32'hC0);
    gap(1);
    check(32'(irq), 32'h1);
    spm(8'h91, 32'h1);
    rd(FSPS_OFF_CTRL, 32'h80);
    rnd = lfsr(rnd);
    bus(1'b1, FSPS_OFF_DATA, {24'h0, 2'h3, rnd[3:0], 2'h3});
    op(8'h89, 16'h0001, FSPS_OP_LOCK, rnd[3:0]);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, FSPS_OFF_PTR, 32'(p));
      spm(8'h89, 32'h2);
      rd(FSPS_OFF_LOAD, {23'h0, 1'b1, p == 1 ? {2'h3, boot_loader_section, mls} : fz[p]});
      gap(1);
    end
    bus(1'b1, FSPS_OFF_CTRL, 32'h83);
    gap(6);
    bus(1'b1, FSPS_OFF_CMD, 32'h1);
    rd(FSPS_OFF_CTRL, 32'h80);
    gap(1);
    fill(6'h07, 16'h1234);
    bus(1'b1, FSPS_OFF_CTRL, 32'h11);
    gap(2);
    bchk(6'h07, 16'hFFFF);
    fill(6'h08, 16'h5678);
    eew <= 1'b1;
    gap(2);
    bchk(6'h08, 16'hFFFF);
    spm(8'h89, 32'h2);
    rd(FSPS_OFF_LOAD, 32'h0);
    spm(8'h03, 32'h1);
    rd(FSPS_OFF_CTRL, 32'h0);
    gap(1);
    eew <= 1'b0;
    complete_run();
  end
endmodule // test_flash_self_program_sequencer
